// >>> design/fsp_pkg.sv
// Purpose: Shared constants, types and helpers of the flash self-program controller.
// Assumes: 250 MHz system clock, 32-bit AXI4-Lite register access.
// Notes: Page geometry is fixed here so that the carrier structs have static widths.
package fsp_pkg;
   localparam int PTR_W = 16;
   localparam int DATA_W = 16;
   localparam int WORD_BITS = 6;
   localparam int PAGE_WORDS = 1 << WORD_BITS;
   localparam int PAGE_W = PTR_W - WORD_BITS - 1;
   localparam int ADDR_W = 8;
   localparam int LOCK_W = 6;
   localparam int CNT_W = 21;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PTR = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STORE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_LOAD = 8'h14;

   localparam int B_EN = 0;
   localparam int B_REEN = 4;
   localparam int B_BUSY = 6;
   localparam int B_IE = 7;
   localparam int B_HALT = 8;
   localparam int B_EEBUSY = 9;
   localparam int B_FUSE = 10;

   localparam logic [5:0] CMD_LOAD = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_LOCK = 6'h09;
   localparam logic [5:0] CMD_REEN = 6'h11;

   localparam logic [2:0] STORE_WINDOW_CYC = 3'h4;
   localparam int CLK_MHZ = 250;
   localparam int OP_MIN_NS = 3700000;
   localparam int OP_MAX_NS = 4500000;
   localparam int OP_MIN_CYC = (OP_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int OP_MAX_CYC = (OP_MAX_NS * CLK_MHZ) / 1000;

   localparam logic [PTR_W-1:0] APP_RESET_ADDR = 16'h0000;
   localparam logic [LOCK_W-1:0] LOCK_RST = 6'h3f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ARMED = 2'h1, ST_BUSY = 2'h3} fsp_state_t;
   typedef enum logic [1:0] {OP_ERASE = 2'h0, OP_WRITE = 2'h1, OP_LOCK = 2'h2} fsp_op_t;

   typedef struct packed {
      logic erase;
      logic write;
      logic lock;
      logic [PAGE_W-1:0] page;
      logic [LOCK_W-1:0] lock_mask;
   } fsp_flash_cmd_t;

   typedef struct packed {
      logic valid;
      logic [WORD_BITS-1:0] idx;
      logic [DATA_W-1:0] data;
   } fsp_flash_word_t;

   function automatic logic [PAGE_W-1:0] page_of(input logic [PTR_W-1:0] ptr);
      page_of = ptr[PTR_W-1:WORD_BITS+1];
   endfunction

   function automatic logic [WORD_BITS-1:0] word_of(input logic [PTR_W-1:0] ptr);
      word_of = ptr[WORD_BITS:1];
   endfunction
endpackage

// >>> design/fsp_page_buf.sv
// Purpose: Temporary page buffer with per-slot fill flags and registered read data.
// Assumes: One write and one read port, both on clk_sys.
// Notes: An empty slot reads as all ones, like erased flash.
`timescale 1ns/1ns
`default_nettype none
module fsp_page_buf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [DEPTH-1:0] full_r;
   logic [WIDTH-1:0] rd_data_r;

   assign rd_data = rd_data_r;

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem_r[wr_idx] <= wr_data;
      end
   end

   // A load in the same cycle as a clear survives it.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         full_r <= '0;
      end
      else
      begin
         if (clr)
         begin
            full_r <= '0;
         end
         if (wr_en)
         begin
            full_r[wr_idx] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rd_data_r <= '1;
      end
      else
      begin
         rd_data_r <= full_r[rd_idx] ? mem_r[rd_idx] : '1;
      end
   end
endmodule
`default_nettype wire

// >>> design/fsp_ctrl.sv
// Purpose: Flash self-program controller with AXI4-Lite registers.
// Assumes: A write to the store offset stands for the core's store instruction.
// Notes: The flash macro receives a one-cycle command and, for a page write, the buffer words.
// What this block does
// - Reset vector is 0x0000 with fuse at one, boot address with fuse at zero.
// - Fuses are inputs only; software has no path to change them.
// - Pointer low bits pick the word in a page, high bits pick the page.
// - Target page is latched at start; later pointer writes do not matter.
// - Lock setting ignores the pointer entirely.
// - Load reads pick the low or high byte by pointer bit zero.
// - Erase command plus store within four cycles erases the indexed page.
// - Programming the no-read-while-write region halts the core; other region does not.
// - Load command plus store puts the data pair into the indexed buffer slot.
// - Buffer clears after page write, on region re-enable, and on reset.
// - A data EEPROM write during page loading discards the buffer.
// - Write command plus store programs the buffer into the indexed page.
// - Enabled interrupt stays asserted while the store enable bit is clear.
// - Erase or write blocks the region and holds its busy flag.
// - Lock command programs each lock bit whose data bit is zero.
// - Lock programming blocks no region and halts nothing.
// - Store enable and command bits clear if no store comes within four cycles.
// - An ongoing EEPROM write blocks every self-program command.
// - Erase, write and lock take between 3.7 ms and 4.5 ms.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fsp_ctrl #(
   parameter int OP_TIME_CYC = fsp_pkg::OP_MIN_CYC,
   parameter logic [fsp_pkg::PAGE_W-1:0] NOREADWHILEWRITE_REGION_FIRST_PAGE = 9'h1c0,
   parameter logic [fsp_pkg::PTR_W-1:0] BOOT_RESET_ADDR = 16'hf000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [fsp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fsp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic boot_vector_fuse,
   output logic [fsp_pkg::PTR_W-1:0] reset_vector,
   input wire logic eeprom_busy,
   input wire logic eeprom_write,
   output fsp_pkg::fsp_flash_cmd_t flash_cmd,
   output fsp_pkg::fsp_flash_word_t flash_word,
   output logic [fsp_pkg::PTR_W-2:0] flash_rd_addr,
   input wire logic [fsp_pkg::DATA_W-1:0] flash_rd_data,
   output logic rww_read_block,
   output logic cpu_halt,
   output logic spm_irq
);
   localparam logic [fsp_pkg::CNT_W-1:0] OP_LAST = fsp_pkg::CNT_W'(OP_TIME_CYC - 1);

   fsp_pkg::fsp_state_t state_r;
   fsp_pkg::fsp_op_t op_r;
   logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
   logic [fsp_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [7:0] ctrl_r;
   logic busy_flag_r, halt_r;
   logic [fsp_pkg::PTR_W-1:0] ptr_r, reset_vector_r;
   logic [fsp_pkg::DATA_W-1:0] data_r;
   logic [fsp_pkg::LOCK_W-1:0] lock_bits_r;
   logic [2:0] win_cnt_r;
   logic [fsp_pkg::CNT_W-1:0] op_cnt_r;
   logic [fsp_pkg::WORD_BITS:0] stream_cnt_r;
   fsp_pkg::fsp_flash_cmd_t flash_cmd_r;
   logic word_valid_r;
   logic [fsp_pkg::WORD_BITS-1:0] word_idx_r;
   logic [fsp_pkg::DATA_W-1:0] buf_rdata;

   // Register bus decode.
   wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
   wire ar_fire = s_axi_arvalid && !rvalid_r;
   wire sel_ctrl = wr_fire && awaddr_r == fsp_pkg::OFF_CTRL;
   wire sel_ptr = wr_fire && awaddr_r == fsp_pkg::OFF_PTR;
   wire sel_data = wr_fire && awaddr_r == fsp_pkg::OFF_DATA;
   wire store_fire = wr_fire && awaddr_r == fsp_pkg::OFF_STORE;
   wire wr_mapped = awaddr_r == fsp_pkg::OFF_CTRL || awaddr_r == fsp_pkg::OFF_PTR
                    || awaddr_r == fsp_pkg::OFF_DATA || awaddr_r == fsp_pkg::OFF_STORE;

   // Command decode.
   wire [5:0] cmd = ctrl_r[5:0];
   wire armed = state_r == fsp_pkg::ST_ARMED;
   wire do_store = armed && store_fire && !eeprom_busy;
   wire arm_req = sel_ctrl && wstrb_r[0] && state_r == fsp_pkg::ST_IDLE
                  && !eeprom_busy && wdata_r[fsp_pkg::B_EN];
   wire do_load = do_store && cmd == fsp_pkg::CMD_LOAD;
   wire do_reen = do_store && cmd == fsp_pkg::CMD_REEN;
   wire start_erase = do_store && cmd == fsp_pkg::CMD_ERASE;
   wire start_write = do_store && cmd == fsp_pkg::CMD_WRITE;
   wire start_lock = do_store && cmd == fsp_pkg::CMD_LOCK;
   wire op_start = start_erase || start_write || start_lock;
   wire win_expire = armed && !do_store && win_cnt_r == 3'h1;
   wire op_done = state_r == fsp_pkg::ST_BUSY && op_cnt_r == OP_LAST;
   wire write_done = op_done && op_r == fsp_pkg::OP_WRITE;
   wire [fsp_pkg::PAGE_W-1:0] ptr_page = fsp_pkg::page_of(ptr_r);
   wire [fsp_pkg::WORD_BITS-1:0] ptr_word = fsp_pkg::word_of(ptr_r);
   wire page_noreadwhilewrite_region = ptr_page >= NOREADWHILEWRITE_REGION_FIRST_PAGE;
   wire buf_clr = write_done || do_reen || eeprom_write;
   wire streaming = state_r == fsp_pkg::ST_BUSY && op_r == fsp_pkg::OP_WRITE && !stream_cnt_r[fsp_pkg::WORD_BITS];

   // Read selection; load reads pick a byte by pointer bit zero.
   wire [7:0] load_byte = ptr_r[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];
   wire [31:0] stat_word = {21'h0, boot_vector_fuse, eeprom_busy, halt_r, 2'h0, lock_bits_r};
   wire [31:0] ctrl_word = {24'h0, ctrl_r[7], busy_flag_r, ctrl_r[5:0]};
   wire rd_ctrl = s_axi_araddr == fsp_pkg::OFF_CTRL;
   wire rd_ptr = s_axi_araddr == fsp_pkg::OFF_PTR;
   wire rd_data = s_axi_araddr == fsp_pkg::OFF_DATA;
   wire rd_stat = s_axi_araddr == fsp_pkg::OFF_STAT;
   wire rd_load = s_axi_araddr == fsp_pkg::OFF_LOAD;
   wire rd_store = s_axi_araddr == fsp_pkg::OFF_STORE;
   wire [31:0] rd_mux = rd_ctrl ? ctrl_word
                      : rd_ptr ? {16'h0, ptr_r}
                      : rd_data ? {16'h0, data_r}
                      : rd_stat ? stat_word
                      : rd_load ? {24'h0, load_byte}
                      : 32'h0;
   wire rd_mapped = rd_ctrl || rd_ptr || rd_data || rd_stat || rd_load || rd_store;

   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign reset_vector = reset_vector_r;
   assign flash_cmd = flash_cmd_r;
   assign flash_word = '{valid: word_valid_r, idx: word_idx_r, data: buf_rdata};
   assign flash_rd_addr = ptr_r[fsp_pkg::PTR_W-1:1];
   assign rww_read_block = busy_flag_r;
   assign cpu_halt = halt_r;
   assign spm_irq = ctrl_r[fsp_pkg::B_IE] && !ctrl_r[fsp_pkg::B_EN];

   fsp_page_buf #(
      .WIDTH(fsp_pkg::DATA_W),
      .DEPTH(fsp_pkg::PAGE_WORDS),
      .AW(fsp_pkg::WORD_BITS)
   ) u_buf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clr(buf_clr),
      .wr_en(do_load),
      .wr_idx(ptr_word),
      .wr_data(data_r),
      .rd_idx(stream_cnt_r[fsp_pkg::WORD_BITS-1:0]),
      .rd_data(buf_rdata)
   );

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= fsp_pkg::RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= fsp_pkg::RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_mapped ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r <= 1'b0;
      end
   end

   // The fuse is sampled here and on status reads; no register write reaches it.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         reset_vector_r <= boot_vector_fuse ? fsp_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ptr_r <= '0;
         data_r <= '0;
      end
      else
      begin
         if (sel_ptr)
         begin
            ptr_r <= {wstrb_r[1] ? wdata_r[15:8] : ptr_r[15:8], wstrb_r[0] ? wdata_r[7:0] : ptr_r[7:0]};
         end
         if (sel_data)
         begin
            data_r <= {wstrb_r[1] ? wdata_r[15:8] : data_r[15:8], wstrb_r[0] ? wdata_r[7:0] : data_r[7:0]};
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_r <= fsp_pkg::ST_IDLE;
         ctrl_r <= '0;
         win_cnt_r <= '0;
         op_r <= fsp_pkg::OP_ERASE;
         op_cnt_r <= '0;
      end
      else
      begin
         if (sel_ctrl && wstrb_r[0])
         begin
            ctrl_r[fsp_pkg::B_IE] <= wdata_r[fsp_pkg::B_IE];
         end
         case (state_r)
            fsp_pkg::ST_IDLE:
            begin
               if (arm_req)
               begin
                  ctrl_r[5:0] <= wdata_r[5:0];
                  win_cnt_r <= fsp_pkg::STORE_WINDOW_CYC;
                  state_r <= fsp_pkg::ST_ARMED;
               end
            end
            fsp_pkg::ST_ARMED:
            begin
               win_cnt_r <= win_cnt_r - 3'h1;
               if (op_start)
               begin
                  op_r <= start_erase ? fsp_pkg::OP_ERASE : start_write ? fsp_pkg::OP_WRITE : fsp_pkg::OP_LOCK;
                  op_cnt_r <= '0;
                  state_r <= fsp_pkg::ST_BUSY;
               end
               else if (do_store || win_expire)
               begin
                  ctrl_r[5:0] <= '0;
                  state_r <= fsp_pkg::ST_IDLE;
               end
            end
            fsp_pkg::ST_BUSY:
            begin
               op_cnt_r <= op_cnt_r + fsp_pkg::CNT_W'(1);
               if (op_done)
               begin
                  ctrl_r[5:0] <= '0;
                  state_r <= fsp_pkg::ST_IDLE;
               end
            end
            default:
            begin
               state_r <= fsp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Region flag, core halt, lock bits and the command to the flash macro.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         busy_flag_r <= 1'b0;
         halt_r <= 1'b0;
         lock_bits_r <= fsp_pkg::LOCK_RST;
         flash_cmd_r <= '0;
      end
      else
      begin
         flash_cmd_r <= '0;
         if (start_erase || start_write)
         begin
            busy_flag_r <= 1'b1;
            halt_r <= page_noreadwhilewrite_region;
         end
         else if (do_reen)
         begin
            busy_flag_r <= 1'b0;
         end
         if (op_done)
         begin
            halt_r <= 1'b0;
         end
         if (op_done && op_r == fsp_pkg::OP_LOCK)
         begin
            lock_bits_r <= lock_bits_r & flash_cmd_r.lock_mask;
         end
         if (op_start)
         begin
            flash_cmd_r.erase <= start_erase;
            flash_cmd_r.write <= start_write;
            flash_cmd_r.lock <= start_lock;
            flash_cmd_r.page <= start_lock ? '0 : ptr_page;
            flash_cmd_r.lock_mask <= data_r[fsp_pkg::LOCK_W-1:0];
         end
         else
         begin
            flash_cmd_r.lock_mask <= flash_cmd_r.lock_mask;
            flash_cmd_r.page <= flash_cmd_r.page;
         end
      end
   end

   // Page write streams the buffer out one word a cycle.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         stream_cnt_r <= '0;
         word_valid_r <= 1'b0;
         word_idx_r <= '0;
      end
      else
      begin
         word_valid_r <= streaming;
         word_idx_r <= stream_cnt_r[fsp_pkg::WORD_BITS-1:0];
         if (op_start)
         begin
            stream_cnt_r <= '0;
         end
         else if (streaming)
         begin
            stream_cnt_r <= stream_cnt_r + 7'h01;
         end
      end
   end

   chk_window_expire: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_r == fsp_pkg::ST_IDLE ##1 armed) ##0 (!store_fire) [*4] |=> state_r == fsp_pkg::ST_IDLE
      && ctrl_r[5:0] == 6'h00) else $error("store window did not close");
   chk_busy_keeps_en: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_r == fsp_pkg::ST_BUSY |-> ctrl_r[fsp_pkg::B_EN]) else $error("store enable dropped early");
   chk_op_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_done |=> state_r == fsp_pkg::ST_IDLE && !ctrl_r[fsp_pkg::B_EN] && op_cnt_r == OP_LAST + fsp_pkg::CNT_W'(1))
      else $error("operation did not end on time");
   chk_page_latched: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_start |=> flash_cmd_r.page == ($past(start_lock) ? '0 : $past(ptr_page))) else $error("page not latched");
   chk_region_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (start_erase || start_write) |=> rww_read_block && state_r == fsp_pkg::ST_BUSY)
      else $error("region not blocked");
   chk_noreadwhilewrite_region_halt: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (start_erase || start_write) |=> cpu_halt == $past(page_noreadwhilewrite_region)) else $error("halt wrong");
   chk_lock_free: assert property (@(posedge clk_sys) disable iff (sys_rst)
      start_lock |=> !cpu_halt && rww_read_block == $past(busy_flag_r)) else $error("lock blocked reads");
   chk_ee_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_r == fsp_pkg::ST_IDLE && eeprom_busy |=> state_r == fsp_pkg::ST_IDLE) else $error("command ran");
   chk_reen_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      do_reen |=> !rww_read_block && state_r == fsp_pkg::ST_IDLE) else $error("re-enable failed");
   chk_irq_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
      op_done && ctrl_r[fsp_pkg::B_IE] |=> spm_irq) else $error("no completion interrupt");
   chk_lock_only_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 (lock_bits_r & ~$past(lock_bits_r)) == 6'h00) else $error("lock bit unprogrammed");
   chk_boot_vector: assert property (@(posedge clk_sys)
      sys_rst ##1 !sys_rst |-> reset_vector == ($past(boot_vector_fuse) ? 16'h0000 : BOOT_RESET_ADDR))
      else $error("wrong reset vector");

   cov_erase: cover property (@(posedge clk_sys) disable iff (sys_rst) start_erase);
   cov_write: cover property (@(posedge clk_sys) disable iff (sys_rst) write_done);
   cov_load: cover property (@(posedge clk_sys) disable iff (sys_rst) do_load);
   cov_expire: cover property (@(posedge clk_sys) disable iff (sys_rst) win_expire);
endmodule
`default_nettype wire

// >>> test/fsp_flash_model.sv
// Purpose: Flash macro stand-in that records commands and streamed buffer words.
// Assumes: Read data is a fixed function of the read address.
// Notes: A counter lets the bench see one-cycle command pulses.
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_model (
   input wire logic clk_sys,
   input wire fsp_pkg::fsp_flash_cmd_t flash_cmd,
   input wire fsp_pkg::fsp_flash_word_t flash_word,
   input wire logic [14:0] flash_rd_addr,
   output logic [15:0] flash_rd_data
);
   int n_cmd = 0;
   logic [8:0] pg = 0;
   logic [15:0] mem [64];
   assign flash_rd_data = ~{1'b0, flash_rd_addr};
   always @(posedge clk_sys)
   begin
      if (flash_cmd.erase || flash_cmd.write || flash_cmd.lock)
      begin
         n_cmd <= n_cmd + 1;
         pg <= flash_cmd.page;
      end
      if (flash_word.valid)
         mem[flash_word.idx] <= flash_word.data;
   end
endmodule
`default_nettype wire

// >>> test/tb_flash_self_program_controller.sv
// Purpose: Self-checking bench for the flash self-program controller.
// Assumes: Operations shortened to 80 cycles.
// Notes: Bus inputs are sampled on the falling edge and driven on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_self_program_controller;
   logic clk_sys = 0;
   logic sys_rst = 1;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, arvalid = 0, fuse = 1, ee_busy = 0, ee_wr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0] bresp, rresp, rsp, bsp;
   logic awready, wready, bvalid, arready, rvalid, block, halt, irq;
   logic [15:0] rvec, fdata;
   logic [14:0] faddr;
   fsp_pkg::fsp_flash_cmd_t fcmd;
   fsp_pkg::fsp_flash_word_t fword;
   int err_total = 0;
   int cmp_count = 0;
   always #2 clk_sys = ~clk_sys;
   fsp_ctrl #(.OP_TIME_CYC(80)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .boot_vector_fuse(fuse), .reset_vector(rvec), .eeprom_busy(ee_busy),
      .eeprom_write(ee_wr), .flash_cmd(fcmd), .flash_word(fword), .flash_rd_addr(faddr),
      .flash_rd_data(fdata), .rww_read_block(block), .cpu_halt(halt), .spm_irq(irq));
   fsp_flash_model flash (.clk_sys(clk_sys), .flash_cmd(fcmd), .flash_word(fword),
      .flash_rd_addr(faddr), .flash_rd_data(fdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bh;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      do
      begin
         @(negedge clk_sys);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         bsp = bresp;
         @(posedge clk_sys);
         if (ah)
            awvalid <= 0;
         if (wh)
            wvalid <= 0;
      end while (!bh);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      logic ah, rh;
      araddr <= a;
      arvalid <= 1;
      do
      begin
         @(negedge clk_sys);
         ah = arvalid && arready;
         rh = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge clk_sys);
         if (ah)
            arvalid <= 0;
      end while (!rh);
   endtask
   task automatic spm(input logic [5:0] c);
      wr(fsp_pkg::OFF_CTRL, {24'h0, 2'b10, c});
      wr(fsp_pkg::OFF_STORE, 32'h0);
   endtask
   task automatic wait_done();
      for (int i = 0; i < 300 && irq !== 1'b1; i++)
         @(posedge clk_sys);
      chk(irq, 1);
   endtask
   task automatic t_vec();
      chk(rvec, 16'h0000);
      fuse <= 0;
      sys_rst <= 1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 0;
      @(posedge clk_sys);
      chk(rvec, 16'hf000);
      fuse <= 1;
   endtask
   task automatic t_load_read();
      wr(fsp_pkg::OFF_PTR, 32'h1235);
      rd_reg(fsp_pkg::OFF_LOAD);
      chk(rd[7:0], 8'hf6);
      wr(fsp_pkg::OFF_PTR, 32'h1234);
      rd_reg(fsp_pkg::OFF_LOAD);
      chk(rd[7:0], 8'he5);
      rd_reg(8'h40);
      chk(rsp, fsp_pkg::RESP_SLVERR);
      wr(8'h40, 32'h0);
      chk(bsp, fsp_pkg::RESP_SLVERR);
      wr(fsp_pkg::OFF_PTR, 32'h0);
      chk(bsp, fsp_pkg::RESP_OKAY);
   endtask
   task automatic t_page(input logic [15:0] d, input logic ee, input logic ld, input logic [15:0] exp);
      wr(fsp_pkg::OFF_PTR, 32'h018a);
      wr(fsp_pkg::OFF_DATA, {16'h0, d});
      if (ld)
      begin
         spm(fsp_pkg::CMD_LOAD);
      end
      ee_wr <= ee;
      @(posedge clk_sys);
      ee_wr <= 0;
      wr(fsp_pkg::OFF_PTR, 32'h0180);
      spm(fsp_pkg::CMD_ERASE);
      wait_done();
      spm(fsp_pkg::CMD_WRITE);
      wr(fsp_pkg::OFF_PTR, 32'h0000);
      rd_reg(fsp_pkg::OFF_CTRL);
      chk(rd[0], 1);
      chk({block, halt}, 2'b10);
      wait_done();
      chk(flash.pg, 9'h003);
      chk(flash.mem[5], exp);
      chk(flash.mem[6], 16'hffff);
      chk(block, 1);
      spm(fsp_pkg::CMD_REEN);
      @(negedge clk_sys);
      chk(block, 0);
      @(posedge clk_sys);
   endtask
   task automatic t_erase_lock();
      wr(fsp_pkg::OFF_PTR, 32'he000);
      spm(fsp_pkg::CMD_ERASE);
      @(negedge clk_sys);
      chk({block, halt}, 2'b11);
      chk(flash.pg, 9'h1c0);
      @(posedge clk_sys);
      wait_done();
      spm(fsp_pkg::CMD_REEN);
      wr(fsp_pkg::OFF_PTR, 32'hffff);
      wr(fsp_pkg::OFF_DATA, 32'h00fa);
      spm(fsp_pkg::CMD_LOCK);
      @(negedge clk_sys);
      chk({block, halt}, 2'b00);
      chk(flash.pg, 9'h000);
      @(posedge clk_sys);
      wait_done();
      rd_reg(fsp_pkg::OFF_STAT);
      chk(rd[5:0], 6'h3a);
   endtask
   task automatic t_refuse();
      int n0;
      n0 = flash.n_cmd;
      wr(fsp_pkg::OFF_CTRL, 32'h83);
      repeat (6) @(posedge clk_sys);
      wr(fsp_pkg::OFF_STORE, 32'h0);
      rd_reg(fsp_pkg::OFF_CTRL);
      chk(rd[0], 0);
      ee_busy <= 1;
      spm(fsp_pkg::CMD_ERASE);
      ee_busy <= 0;
      chk(flash.n_cmd, n0);
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 0;
      @(posedge clk_sys);
      t_vec();
      t_load_read();
      t_page(16'h1234, 1'b0, 1'b1, 16'h1234);
      t_page(16'h1234, 1'b0, 1'b0, 16'hffff);
      t_page(16'h1111, 1'b1, 1'b1, 16'hffff);
      t_erase_lock();
      t_refuse();
      print_verdict();
   end
   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
